// File: inc/wsm_regs.svh
`ifndef WSM_REGS_SVH
`define WSM_REGS_SVH

// Clock and timebase
`define WSM_CLK_HZ          20000000
`define WSM_TB_FINE_US      10000
`define WSM_TB_FINE_CYC     ((`WSM_CLK_HZ / 1000000) * `WSM_TB_FINE_US)
`define WSM_FINE_PER_COARSE 4'h9
`define WSM_COARSE_PER_MIN  10'h257

// Percent scale, 0.1 % units
`define WSM_PCT_FULL        32'h000003E8

// Factory settings for the configuration ports
`define WSM_DEF_SLEEP_DELAY 16'h0014
`define WSM_DEF_DECEL_TIME  16'h0BB8
`define WSM_DEF_WAKE_TOL    16'h0064
`define WSM_DEF_WAKE_DELAY  16'h0014
`define WSM_DEF_OVER_THR    16'h0384
`define WSM_DEF_UNDER_THR   16'h0000
`define WSM_DEF_ALARM_DELAY 16'h01F4
`define WSM_DEF_SHORT_THR   16'h0000
`define WSM_DEF_SHORT_DELAY 16'h00C8
`define WSM_DEF_RESTART     16'h0000
`define WSM_DEF_DWELL       16'h0064

// Delay channel indices
`define WSM_CH_SLEEP        0
`define WSM_CH_WAKE         1
`define WSM_CH_OVER         2
`define WSM_CH_UNDER        3
`define WSM_CH_SHORT        4
`define WSM_CH_DWELL        5
`define WSM_CH_RESTART      6
`define WSM_NUM_CH          7

`endif

// File: inc/wsm_pkg.sv
`default_nettype none
package wsm_pkg;

   typedef enum logic [6:0] {
      WSM_IDLE      = 7'h01,
      WSM_REGULATE  = 7'h02,
      WSM_SLEEP_DET = 7'h04,
      WSM_RAMP      = 7'h08,
      WSM_DWELL     = 7'h10,
      WSM_ZERO      = 7'h20,
      WSM_FAULT     = 7'h40
   } wsm_state_t;

endpackage
`default_nettype wire

// File: logic/wsm_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "wsm_regs.svh"

module wsm_tick #(
   parameter int CYC_FINE = `WSM_TB_FINE_CYC
) (
   input  wire logic clk,
   input  wire logic rst,
   output logic      tick_fine,
   output logic      tick_coarse,
   output logic      tick_min
);

   logic [17:0] cyc_r;
   logic [3:0]  fine_r;
   logic [9:0]  coarse_r;
   logic        wrap_fine;
   logic        wrap_coarse;

   assign wrap_fine   = (cyc_r == 18'(CYC_FINE - 1));
   assign wrap_coarse = wrap_fine && (fine_r == `WSM_FINE_PER_COARSE);

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cyc_r <= 18'h00000;
      end else if (wrap_fine) begin
         cyc_r <= 18'h00000;
      end else begin
         cyc_r <= cyc_r + 18'h00001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fine_r <= 4'h0;
      end else if (wrap_coarse) begin
         fine_r <= 4'h0;
      end else if (wrap_fine) begin
         fine_r <= fine_r + 4'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         coarse_r <= 10'h000;
      end else if (wrap_coarse && coarse_r == `WSM_COARSE_PER_MIN) begin
         coarse_r <= 10'h000;
      end else if (wrap_coarse) begin
         coarse_r <= coarse_r + 10'h001;
      end
   end

   // Single-cycle strobes, registered so all users see them together
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_fine   <= 1'b0;
         tick_coarse <= 1'b0;
         tick_min    <= 1'b0;
      end else begin
         tick_fine   <= wrap_fine;
         tick_coarse <= wrap_coarse;
         tick_min    <= wrap_coarse && (coarse_r == `WSM_COARSE_PER_MIN);
      end
   end

endmodule
`default_nettype wire

// File: logic/wsm_delay.sv
`timescale 1ns/1ps
`default_nettype none

module wsm_delay (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        tick,
   input  wire logic        cond,
   input  wire logic [15:0] limit,
   output logic             done
);

   logic [15:0] cnt_r;

   // Zero limit means done at once while the condition holds
   assign done = cond && (cnt_r >= limit);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 16'h0000;
      end else if (!cond) begin
         cnt_r <= 16'h0000;
      end else if (tick && !done) begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

endmodule
`default_nettype wire

// File: logic/wsm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wsm_regs.svh"

module wsm_top
   import wsm_pkg::*;
#(
   parameter int CYC_FINE = `WSM_TB_FINE_CYC
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        RUN,
   input  wire logic        FAULT_RESET,
   input  wire logic [15:0] SET_PRESSURE,
   input  wire logic [15:0] FEEDBACK,
   input  wire logic [15:0] PID_FREQ,
   input  wire logic [15:0] FREQ_UPPER,
   input  wire logic [15:0] FREQ_LOWER,
   input  wire logic [15:0] SLEEP_TOLERANCE,
   input  wire logic [15:0] SLEEP_DETECT_DELAY,
   input  wire logic [15:0] SLEEP_DECEL_TIME,
   input  wire logic [15:0] WAKE_TOLERANCE,
   input  wire logic [15:0] WAKE_DETECT_DELAY,
   input  wire logic [15:0] OVERPRESSURE_THRESHOLD,
   input  wire logic [15:0] UNDERPRESSURE_THRESHOLD,
   input  wire logic [15:0] PRESSURE_ALARM_DELAY,
   input  wire logic [15:0] SHORTAGE_THRESHOLD,
   input  wire logic [15:0] SHORTAGE_DETECT_DELAY,
   input  wire logic [15:0] SHORTAGE_RESTART_WAIT,
   input  wire logic [15:0] LOWER_LIMIT_DWELL,
   output logic      [15:0] FREQ_CMD,
   output logic      [6:0]  STATE,
   output logic             REGULATING,
   output logic             SLEEP_ACTIVE,
   output logic             SLEEP_DET_FAIL,
   output logic             WAKE_FAIL,
   output logic             OVERPRESSURE_IND,
   output logic             UNDERPRESSURE_IND,
   output logic             SHORTAGE_IND,
   output logic             WATER_SHORTAGE_FAULT
);

   wsm_state_t  state_r;
   wsm_state_t  state_nxt;
   logic [15:0] freq_r;
   logic [31:0] acc_r;
   logic [31:0] acc_nxt;
   logic        wake_cond_r;

   logic        tick_fine;
   logic        tick_coarse;
   logic        tick_min;

   logic [31:0] fb_scaled;
   logic [31:0] sleep_thr_scaled;
   logic [31:0] wake_thr_scaled;
   logic [31:0] short_thr_scaled;
   logic        above_sleep;
   logic        below_sleep;
   logic        below_wake;
   logic        asleep;
   logic        at_upper;
   logic        ramp_step;
   logic [15:0] decel_eff;

   logic [`WSM_NUM_CH-1:0] ch_cond;
   logic [`WSM_NUM_CH-1:0] ch_tick;
   logic [`WSM_NUM_CH-1:0] ch_done;
   logic [15:0]            ch_limit [`WSM_NUM_CH];

   ////////////////////////////////////////////////////////////////////////
   // Timebase

   wsm_tick #(
      .CYC_FINE    (CYC_FINE)
   ) u_tick (
      .clk         (CLK),
      .rst         (RST),
      .tick_fine   (tick_fine),
      .tick_coarse (tick_coarse),
      .tick_min    (tick_min)
   );

   ////////////////////////////////////////////////////////////////////////
   // Thresholds, compared as products to avoid a divider

   assign fb_scaled = 32'(FEEDBACK) * `WSM_PCT_FULL;

   // Tolerance above full scale clamps to zero threshold
   assign sleep_thr_scaled = (32'(SLEEP_TOLERANCE) >= `WSM_PCT_FULL)
      ? 32'h00000000
      : 32'(SET_PRESSURE) * (`WSM_PCT_FULL - 32'(SLEEP_TOLERANCE));
   assign wake_thr_scaled = (32'(WAKE_TOLERANCE) >= `WSM_PCT_FULL)
      ? 32'h00000000
      : 32'(SET_PRESSURE) * (`WSM_PCT_FULL - 32'(WAKE_TOLERANCE));
   assign short_thr_scaled = 32'(SET_PRESSURE) * 32'(SHORTAGE_THRESHOLD);

   assign above_sleep = fb_scaled > sleep_thr_scaled;
   assign below_sleep = fb_scaled < sleep_thr_scaled;
   assign below_wake  = fb_scaled < wake_thr_scaled;
   assign asleep      = (state_r == WSM_DWELL) || (state_r == WSM_ZERO);
   assign at_upper    = PID_FREQ >= FREQ_UPPER;

   ////////////////////////////////////////////////////////////////////////
   // Delay channels

   assign ch_cond[`WSM_CH_SLEEP] = (state_r == WSM_SLEEP_DET) && above_sleep;
   assign ch_cond[`WSM_CH_WAKE]  = asleep && below_wake;
   assign ch_cond[`WSM_CH_OVER]  = (OVERPRESSURE_THRESHOLD != 16'h0000)
      && (FEEDBACK >= OVERPRESSURE_THRESHOLD);
   assign ch_cond[`WSM_CH_UNDER] = (UNDERPRESSURE_THRESHOLD != 16'h0000)
      && (FEEDBACK <= UNDERPRESSURE_THRESHOLD);
   assign ch_cond[`WSM_CH_SHORT] = ((state_r == WSM_REGULATE)
      || (state_r == WSM_SLEEP_DET)) && at_upper
      && (fb_scaled <= short_thr_scaled);
   assign ch_cond[`WSM_CH_DWELL] = (state_r == WSM_DWELL);
   assign ch_cond[`WSM_CH_RESTART] = (state_r == WSM_FAULT)
      && (SHORTAGE_RESTART_WAIT != 16'h0000);

   assign ch_limit[`WSM_CH_SLEEP]   = SLEEP_DETECT_DELAY;
   assign ch_limit[`WSM_CH_WAKE]    = WAKE_DETECT_DELAY;
   assign ch_limit[`WSM_CH_OVER]    = PRESSURE_ALARM_DELAY;
   assign ch_limit[`WSM_CH_UNDER]   = PRESSURE_ALARM_DELAY;
   assign ch_limit[`WSM_CH_SHORT]   = SHORTAGE_DETECT_DELAY;
   assign ch_limit[`WSM_CH_DWELL]   = LOWER_LIMIT_DWELL;
   assign ch_limit[`WSM_CH_RESTART] = SHORTAGE_RESTART_WAIT;

   // Restart wait counts minutes, every other delay tenths of a second
   assign ch_tick = {tick_min, {(`WSM_NUM_CH-1){tick_coarse}}};

   generate
      for (genvar ch = 0; ch < `WSM_NUM_CH; ch++) begin : g_delay
         wsm_delay u_delay (
            .clk   (CLK),
            .rst   (RST),
            .tick  (ch_tick[ch]),
            .cond  (ch_cond[ch]),
            .limit (ch_limit[ch]),
            .done  (ch_done[ch])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         WSM_IDLE: begin
            if (RUN) begin
               state_nxt = WSM_REGULATE;
            end
         end
         WSM_REGULATE: begin
            if (ch_done[`WSM_CH_SHORT]) begin
               state_nxt = WSM_FAULT;
            end else if (above_sleep) begin
               state_nxt = WSM_SLEEP_DET;
            end
         end
         WSM_SLEEP_DET: begin
            if (ch_done[`WSM_CH_SHORT]) begin
               state_nxt = WSM_FAULT;
            end else if (below_sleep) begin
               state_nxt = WSM_REGULATE;
            end else if (ch_done[`WSM_CH_SLEEP]) begin
               state_nxt = WSM_RAMP;
            end
         end
         WSM_RAMP: begin
            if (below_sleep) begin
               state_nxt = WSM_REGULATE;
            end else if (freq_r <= FREQ_LOWER) begin
               state_nxt = WSM_DWELL;
            end
         end
         WSM_DWELL: begin
            if (ch_done[`WSM_CH_WAKE]) begin
               state_nxt = WSM_REGULATE;
            end else if (ch_done[`WSM_CH_DWELL]) begin
               state_nxt = WSM_ZERO;
            end
         end
         WSM_ZERO: begin
            if (ch_done[`WSM_CH_WAKE]) begin
               state_nxt = WSM_REGULATE;
            end
         end
         WSM_FAULT: begin
            if (ch_done[`WSM_CH_RESTART] || FAULT_RESET) begin
               state_nxt = RUN ? WSM_REGULATE : WSM_IDLE;
            end
         end
         default: begin
            state_nxt = WSM_IDLE;
         end
      endcase
      // Stopping the drive abandons sleep, but a fault stays latched
      if (!RUN && state_r != WSM_FAULT && state_nxt != WSM_FAULT) begin
         state_nxt = WSM_IDLE;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_r <= WSM_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sleep ramp: upper limit per fine tick over the decel time

   assign decel_eff = (SLEEP_DECEL_TIME == 16'h0000) ? 16'h0001
                                                     : SLEEP_DECEL_TIME;
   assign ramp_step = (state_r == WSM_RAMP) && (acc_r >= 32'(decel_eff))
                      && (freq_r > FREQ_LOWER);

   always_comb begin
      acc_nxt = acc_r;
      if (state_r != WSM_RAMP) begin
         acc_nxt = 32'h00000000;
      end else begin
         if (tick_fine) begin
            acc_nxt = acc_nxt + 32'(FREQ_UPPER);
         end
         if (ramp_step) begin
            acc_nxt = acc_nxt - 32'(decel_eff);
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         acc_r <= 32'h00000000;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   // One step per clock keeps the ramp exact for any decel setting
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         freq_r <= 16'h0000;
      end else begin
         unique case (state_nxt)
            WSM_REGULATE, WSM_SLEEP_DET: begin
               freq_r <= PID_FREQ;
            end
            WSM_RAMP: begin
               if (ramp_step) begin
                  freq_r <= freq_r - 16'h0001;
               end
            end
            WSM_DWELL: begin
               freq_r <= FREQ_LOWER;
            end
            default: begin
               freq_r <= 16'h0000;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Indications and pulses

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wake_cond_r <= 1'b0;
      end else begin
         wake_cond_r <= ch_cond[`WSM_CH_WAKE];
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         SLEEP_DET_FAIL <= 1'b0;
         WAKE_FAIL      <= 1'b0;
      end else begin
         SLEEP_DET_FAIL <= ((state_r == WSM_SLEEP_DET)
            || (state_r == WSM_RAMP)) && below_sleep
            && !ch_done[`WSM_CH_SHORT];
         WAKE_FAIL <= asleep && wake_cond_r
            && !ch_cond[`WSM_CH_WAKE];
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         OVERPRESSURE_IND  <= 1'b0;
         UNDERPRESSURE_IND <= 1'b0;
      end else begin
         OVERPRESSURE_IND  <= ch_done[`WSM_CH_OVER];
         UNDERPRESSURE_IND <= ch_done[`WSM_CH_UNDER];
      end
   end

   // Shortage flags track the fault state so they clear with it
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         SHORTAGE_IND         <= 1'b0;
         WATER_SHORTAGE_FAULT <= 1'b0;
      end else begin
         SHORTAGE_IND         <= (state_nxt == WSM_FAULT);
         WATER_SHORTAGE_FAULT <= (state_nxt == WSM_FAULT);
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         REGULATING   <= 1'b0;
         SLEEP_ACTIVE <= 1'b0;
      end else begin
         REGULATING   <= (state_nxt == WSM_REGULATE)
                         || (state_nxt == WSM_SLEEP_DET);
         SLEEP_ACTIVE <= (state_nxt == WSM_RAMP) || (state_nxt == WSM_DWELL)
                         || (state_nxt == WSM_ZERO);
      end
   end

   assign FREQ_CMD = freq_r;
   assign STATE    = state_r;

endmodule
`default_nettype wire

// File: tb/wsm_sva.sv
`timescale 1ns/1ps
`default_nettype none
module wsm_sva
   import wsm_pkg::*;
#(
   parameter int CYC_FINE = 2
) (
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        RUN,
   input wire logic [15:0] FEEDBACK,
   input wire logic [15:0] FREQ_LOWER,
   input wire logic [15:0] OVERPRESSURE_THRESHOLD,
   input wire logic [15:0] UNDERPRESSURE_THRESHOLD,
   input wire logic [15:0] FREQ_CMD,
   input wire logic [6:0]  STATE,
   input wire logic        REGULATING,
   input wire logic        SLEEP_ACTIVE,
   input wire logic        SLEEP_DET_FAIL,
   input wire logic        WAKE_FAIL,
   input wire logic        OVERPRESSURE_IND,
   input wire logic        UNDERPRESSURE_IND,
   input wire logic        SHORTAGE_IND,
   input wire logic        WATER_SHORTAGE_FAULT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_ramp; STATE == WSM_RAMP; endsequence
   sequence s_dwell; STATE == WSM_DWELL; endsequence
   sequence s_fail; SLEEP_DET_FAIL && STATE == WSM_REGULATE; endsequence
   property p_flags;
      WATER_SHORTAGE_FAULT == SHORTAGE_IND
         && SHORTAGE_IND == (STATE == WSM_FAULT);
   endproperty
   a_flags: assert property (p_flags) else $error("fault flags split");
   property p_fzero; WATER_SHORTAGE_FAULT |-> FREQ_CMD == 16'h0000;
   endproperty
   a_fzero: assert property (p_fzero) else $error("fault freq");
   property p_fail;
      SLEEP_DET_FAIL |-> ($past(STATE) == WSM_SLEEP_DET
         || $past(STATE) == WSM_RAMP) and (s_fail ##1 !SLEEP_DET_FAIL);
   endproperty
   a_fail: assert property (p_fail) else $error("sleep fail pulse");
   property p_reg;
      REGULATING == (STATE == WSM_REGULATE || STATE == WSM_SLEEP_DET);
   endproperty
   a_reg: assert property (p_reg) else $error("regulating flag");
   property p_slp; SLEEP_ACTIVE == (STATE == WSM_RAMP
      || STATE == WSM_DWELL || STATE == WSM_ZERO);
   endproperty
   a_slp: assert property (p_slp) else $error("sleep flag");
   property p_ramp; s_ramp ##1 s_ramp |-> FREQ_CMD <= $past(FREQ_CMD);
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp rises");
   property p_dwell; s_dwell ##1 s_dwell |-> FREQ_CMD == FREQ_LOWER;
   endproperty
   a_dwell: assert property (p_dwell) else $error("dwell freq");
   property p_enter; $rose(STATE == WSM_RAMP) |->
      $past(STATE) == WSM_SLEEP_DET;
   endproperty
   a_enter: assert property (p_enter) else $error("ramp entry");
   property p_idle; !RUN && STATE != WSM_FAULT |=>
      STATE == WSM_IDLE && FREQ_CMD == 16'h0000;
   endproperty
   a_idle: assert property (p_idle) else $error("run low");
   property p_ovoff; (OVERPRESSURE_THRESHOLD == 16'h0000) [*3] |->
      !OVERPRESSURE_IND;
   endproperty
   a_ovoff: assert property (p_ovoff) else $error("over off");
   property p_ovclr; FEEDBACK < OVERPRESSURE_THRESHOLD |=>
      !OVERPRESSURE_IND;
   endproperty
   a_ovclr: assert property (p_ovclr) else $error("over clear");
   property p_unclr; FEEDBACK > UNDERPRESSURE_THRESHOLD |=>
      !UNDERPRESSURE_IND;
   endproperty
   a_unclr: assert property (p_unclr) else $error("under clear");
   property p_wake; WAKE_FAIL |-> SLEEP_ACTIVE ##1 !WAKE_FAIL;
   endproperty
   a_wake: assert property (p_wake) else $error("wake fail pulse");
endmodule
bind wsm_top wsm_sva #(.CYC_FINE(CYC_FINE)) i_wsm_sva (.CLK(CLK),
   .RST(RST), .RUN(RUN), .FEEDBACK(FEEDBACK), .FREQ_LOWER(FREQ_LOWER),
   .OVERPRESSURE_THRESHOLD(OVERPRESSURE_THRESHOLD),
   .UNDERPRESSURE_THRESHOLD(UNDERPRESSURE_THRESHOLD),
   .FREQ_CMD(FREQ_CMD), .STATE(STATE), .REGULATING(REGULATING),
   .SLEEP_ACTIVE(SLEEP_ACTIVE), .SLEEP_DET_FAIL(SLEEP_DET_FAIL),
   .WAKE_FAIL(WAKE_FAIL), .OVERPRESSURE_IND(OVERPRESSURE_IND),
   .UNDERPRESSURE_IND(UNDERPRESSURE_IND), .SHORTAGE_IND(SHORTAGE_IND),
   .WATER_SHORTAGE_FAULT(WATER_SHORTAGE_FAULT));
`default_nettype wire

// File: tb/wsm_plant.sv
`timescale 1ns/1ps
`default_nettype none
// Sensor and PID loop stand-in; slow mode slews one count a clock
module wsm_plant (
   input wire logic        clk,
   input wire logic        slow,
   input wire logic [15:0] p_tgt,
   input wire logic [15:0] f_tgt,
   output logic     [15:0] feedback,
   output logic     [15:0] pid_freq
);
   always_ff @(posedge clk) begin
      pid_freq <= f_tgt;
      if (!slow || feedback == p_tgt)
         feedback <= p_tgt;
      else if (feedback < p_tgt)
         feedback <= feedback + 16'h0001;
      else
         feedback <= feedback - 16'h0001;
   end
endmodule
`default_nettype wire

// File: tb/test_wsm_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_wsm_top;
   import wsm_pkg::*;
   localparam int CF = 2;
   logic clk, rst, run, f_rst, slow;
   logic [15:0] pt, ft, fb, pid, up, lo, set_p, s_tol, s_dly, dec, w_tol;
   logic [15:0] w_dly, ov, un, a_dly, sh, sh_dly, rs, dw, fcmd, thr;
   logic [6:0]  st, last_st;
   logic        reg_o, slp_o, sfail, wfail, ov_i, un_i, sh_i, flt;
   wsm_state_t  exp_q[$];
   int          n_errors, cmp_count, seed, n;
   wsm_plant i_wsm_plant (.clk(clk), .slow(slow), .p_tgt(pt), .f_tgt(ft),
      .feedback(fb), .pid_freq(pid));
   wsm_top #(.CYC_FINE(CF)) i_wsm_top (.CLK(clk), .RST(rst), .RUN(run),
      .FAULT_RESET(f_rst), .SET_PRESSURE(set_p), .FEEDBACK(fb),
      .PID_FREQ(pid), .FREQ_UPPER(up), .FREQ_LOWER(lo),
      .SLEEP_TOLERANCE(s_tol), .SLEEP_DETECT_DELAY(s_dly),
      .SLEEP_DECEL_TIME(dec), .WAKE_TOLERANCE(w_tol),
      .WAKE_DETECT_DELAY(w_dly), .OVERPRESSURE_THRESHOLD(ov),
      .UNDERPRESSURE_THRESHOLD(un), .PRESSURE_ALARM_DELAY(a_dly),
      .SHORTAGE_THRESHOLD(sh), .SHORTAGE_DETECT_DELAY(sh_dly),
      .SHORTAGE_RESTART_WAIT(rs), .LOWER_LIMIT_DWELL(dw), .FREQ_CMD(fcmd),
      .STATE(st), .REGULATING(reg_o), .SLEEP_ACTIVE(slp_o),
      .SLEEP_DET_FAIL(sfail), .WAKE_FAIL(wfail), .OVERPRESSURE_IND(ov_i),
      .UNDERPRESSURE_IND(un_i), .SHORTAGE_IND(sh_i),
      .WATER_SHORTAGE_FAULT(flt));
   ////////////////////////////////////////////////////////////////////
   task check(input string nm, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task rng(input string nm, input int lo_c, input int hi_c);
      check(nm, 16'(n >= lo_c && n <= hi_c), 16'h0001);
   endtask
   task close_out;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   function logic pick(input int k, input logic [6:0] s);
      case (k)
         0: return st === s;
         1: return ov_i;
         2: return un_i;
         3: return flt;
         4: return wfail;
         5: return sfail;
         default: return !flt;
      endcase
   endfunction
   // Bounded wait; leaves the cycle count in n
   task wait_on(input int k, input logic [6:0] s, input int lim);
      n = 0;
      while (pick(k, s) !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (pick(k, s) !== 1'b1) check("wait", 16'(k), 16'hFFFF);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Every state change is matched against the oldest note
   always @(negedge clk) begin
      if (!rst && st !== last_st) begin
         last_st = st;
         if (exp_q.size() == 0)
            check("state_extra", 16'(st), 16'h0000);
         else
            check("state", 16'(st), 16'(exp_q.pop_front()));
      end
   end
   initial begin
      repeat (40000) @(posedge clk);
      check("watchdog", 16'h0000, 16'h0001);
      close_out();
   end
   initial begin
      seed = 32'he9c5; rst = 1'b1; run = 1'b0; f_rst = 1'b0; slow = 1'b0;
      pt = 16'h0000; ft = 16'h0050; up = 16'h0064; lo = 16'h0014;
      set_p = 16'h01F4; s_tol = 16'h0064; s_dly = 16'h0002; dw = 16'h0002;
      dec = 16'h00C8; w_tol = 16'h0064; w_dly = 16'h0002; ov = 16'h0000;
      un = 16'h0000; a_dly = 16'h0004; sh = 16'h0000; sh_dly = 16'h0002;
      rs = 16'h0002; last_st = 7'h01;
      exp_q = '{WSM_REGULATE, WSM_SLEEP_DET, WSM_REGULATE, WSM_SLEEP_DET,
         WSM_RAMP, WSM_DWELL, WSM_ZERO, WSM_REGULATE, WSM_FAULT,
         WSM_REGULATE, WSM_FAULT, WSM_REGULATE, WSM_IDLE};
      repeat (6) @(negedge clk);
      check("rst_st", 16'(st), 16'(WSM_IDLE));
      check("rst_out", {fcmd[7:0], reg_o, slp_o, sfail, wfail, ov_i, un_i,
         sh_i, flt}, 16'h0000);
      rst = 1'b0;
      @(negedge clk);
      run = 1'b1;
      thr = 16'(set_p * (1000 - s_tol) / 1000);
      pt = thr;
      wait_on(0, WSM_REGULATE, 4);
      repeat (70) @(negedge clk); // Equal to threshold: no detection
      check("freq_reg", fcmd, ft);
      check("regulating", {15'h0000, reg_o}, 16'h0001);
      pt = thr + 16'h0001;
      wait_on(0, WSM_SLEEP_DET, 4);
      repeat (3) @(negedge clk);
      pt = thr - 16'h0001;
      wait_on(5, 7'h00, 4);
      slow = 1'b1;
      pt = thr + 16'h000A;
      wait_on(0, WSM_SLEEP_DET, 24);
      slow = 1'b0;
      n = 0;
      while (st !== WSM_RAMP && n < 100) begin
         @(negedge clk);
         pt = 16'(thr + 5 + ($random(seed) & 7));
         n++;
      end
      rng("sleep_dly", 18, 45);
      // Upper 100 over 2 s: 60 counts down to lower take 240 clocks
      wait_on(0, WSM_DWELL, 300);
      rng("ramp_time", 228, 252);
      check("dwell_freq", fcmd, lo);
      check("sleep_act", {15'h0000, slp_o}, 16'h0001);
      wait_on(0, WSM_ZERO, 64);
      rng("dwell_time", 18, 45);
      check("zero_freq", fcmd, 16'h0000);
      thr = 16'(set_p * (1000 - w_tol) / 1000);
      pt = thr - 16'h0001;
      repeat (8) @(negedge clk);
      pt = thr;
      wait_on(4, 7'h00, 6);
      repeat (60) @(negedge clk); // Equal to wake level: stays asleep
      pt = thr - 16'h0001;
      wait_on(0, WSM_REGULATE, 64);
      rng("wake_dly", 20, 45);
      set_p = 16'h03E8; s_tol = 16'h0000; ov = 16'h0384; un = 16'h0064;
      pt = 16'h03B6;
      repeat (40) @(negedge clk);
      pt = ov - 16'h0001;
      repeat (2) @(negedge clk);
      pt = ov;
      wait_on(1, 7'h00, 120);
      rng("over_dly", 60, 84);
      pt = un;
      wait_on(2, 7'h00, 120);
      rng("under_dly", 60, 84);
      sh = 16'h0064;
      ft = up;
      wait_on(3, 7'h00, 64);
      rng("short_dly", 20, 45);
      check("short_ind", {15'h0000, sh_i}, 16'h0001);
      pt = 16'h01F4;
      ft = 16'h0050;
      wait_on(6, 7'h00, 25000);
      rng("restart", 11990, 24050);
      rs = 16'h0000;
      pt = un;
      ft = up;
      wait_on(3, 7'h00, 64);
      repeat (30) @(negedge clk); // Zero wait: fault must hold
      check("no_restart", {15'h0000, flt}, 16'h0001);
      pt = 16'h01F4;
      ft = 16'h0050;
      f_rst = 1'b1;
      wait_on(6, 7'h00, 4);
      f_rst = 1'b0;
      run = 1'b0;
      wait_on(0, WSM_IDLE, 3);
      check("idle_freq", fcmd, 16'h0000);
      @(negedge clk);
      check("queue_left", 16'(exp_q.size()), 16'h0000);
      close_out();
   end
endmodule
`default_nettype wire
